// ===== pm_cmd_regs.svh
// Purpose: Constants for the power manager command decoder.
// Assumes: Included by bare name; defines only.
// Notes: Data stream bit n maps to byte bit 8-n.
`ifndef PM_CMD_REGS_SVH
`define PM_CMD_REGS_SVH

// Command codes on the address port; bit 2 set marks an offset command.
`define CMD_OVR 3'h0
`define CMD_FSW 3'h1
`define CMD_DRP 3'h2
`define CMD_FLG 3'h3
`define CMD_OFS_BIT 2
`define CMD_CORE_BIT 1
`define CMD_AUX_BIT 0

// Read addresses.
`define RD_OVR 3'h0
`define RD_FSW 3'h1
`define RD_DRP 3'h2
`define RD_FLG 3'h3
`define RD_CORE_OFS 3'h4
`define RD_AUX_OFS 3'h5
`define RD_STATUS 3'h6

// Field positions inside the data byte.
`define OFS_SIGN 5
`define OFS_HI 4
`define AUXF_HI 3
`define AUXF_LO 2
`define COREF_HI 1
`define COREF_LO 0
`define FSW_HI 2
`define TH_HI 4
`define TH_LO 3
`define FLG_CHOICE 2
`define FLG_HINT 1
`define FLG_SHED 0

// Reset values.
`define OVR_RST 2'h0
`define FSW_RST 3'h0
`define DRP_RST 2'h0
`define TH_RST 2'h0
`define CHOICE_RST 1'h0
`define HINT_RST 1'h1
`define SHED_RST 1'h0

// Voltages in millivolts.
`define OFS_STEP_MV 17'h00032
`define CORE_MAX_MV 17'h00AF0
`define AUX_MAX_OFS_MV 17'h00258
`define OVR_250_MV 10'h0FA
`define OVR_450_MV 10'h1C2
`define OVR_650_MV 10'h28A
`define OVR_850_MV 10'h352

// Frequency trim in percent, two's complement.
`define FSW_M10 6'h36
`define FSW_M20 6'h2C
`define FSW_P10 6'h0A
`define FSW_P20 6'h14

// Offset step pacing.
`define CLK_NS 10
`define STEP_NS 1000
`define STEP_CYCLES ((`STEP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== pm_cmd_pkg.sv
// Purpose: Types shared by the power manager command decoder.
// Assumes: Nothing beyond the language.
// Notes: Constants live in pm_cmd_regs.svh.
package pm_cmd_pkg;
    typedef enum logic {STEP_IDLE, STEP_MOVING} step_state_t;
endpackage

// ===== offset_stepper.sv
// Purpose: Walks one section's offset code toward its target, one code per tick.
// Assumes: stepTick is a one-cycle enable from a divider.
// Notes: A new target may arrive at any time, also mid-walk.
`include "pm_cmd_regs.svh"
module offset_stepper (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stepTick,
    input wire logic loadTarget,
    input wire logic signed [5:0] newTarget,
    output logic signed [5:0] offsetNow,
    output logic busy
);
    pm_cmd_pkg::step_state_t state_r, state_nxt;
    logic signed [5:0] target_r, target_nxt;
    logic signed [5:0] ofs_r, ofs_nxt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Direction follows the newest target so a retarget never overshoots.
    always_comb begin
        target_nxt = loadTarget ? newTarget : target_r;
        ofs_nxt = ofs_r;
        state_nxt = state_r;
        unique case (state_r)
            pm_cmd_pkg::STEP_IDLE: begin
                if (target_nxt != ofs_r) begin
                    state_nxt = pm_cmd_pkg::STEP_MOVING;
                end
            end
            pm_cmd_pkg::STEP_MOVING: begin
                if (stepTick && target_nxt > ofs_r) begin
                    ofs_nxt = ofs_r + 6'sh01;
                end else if (stepTick && target_nxt < ofs_r) begin
                    ofs_nxt = ofs_r - 6'sh01;
                end
                if (ofs_nxt == target_nxt) begin
                    state_nxt = pm_cmd_pkg::STEP_IDLE;
                end
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= pm_cmd_pkg::STEP_IDLE;
            target_r <= 6'sh00;
            ofs_r <= 6'sh00;
        end else begin
            state_r <= state_nxt;
            target_r <= target_nxt;
            ofs_r <= ofs_nxt;
        end
    end

    assign offsetNow = ofs_r;
    assign busy = (state_r == pm_cmd_pkg::STEP_MOVING);

    AST_STEP_ONE: assert property (!$stable(ofs_r) |-> $past(stepTick) &&
        (ofs_r - $past(ofs_r) == 6'sh01 || $past(ofs_r) - ofs_r == 6'sh01))
        else $error("Offset moved by more than one code or without a tick.");
    AST_RETARGET: assert property (loadTarget |=> target_r == $past(newTarget))
        else $error("New target was not taken.");
    AST_ARRIVE: assert property (!busy |-> ofs_r == target_r)
        else $error("Stepper went idle away from its target.");
endmodule // offset_stepper

// ===== power_manager_command_decoder.sv
// Purpose: Decodes power manager commands and holds the regulation settings.
// Assumes: A command is one write: address is the command code, data the stream.
// Notes: Bus framing, analog regulation and threshold comparison are outside.
//
// Behaviour
// - Offset from 0 to 1.550 V in 50 mV steps added to reference.
// - Offset is a 5-bit code, 0.05 V per count.
// - Core reference clamps at 2.8 V.
// - Auxiliary reference never exceeds programmed reference plus 600 mV.
// - Offset change steps toward the target one code at a time.
// - A new offset command mid-walk replaces the target.
// - Section bits: 11 both, 10 core, 01 auxiliary, 00 ignored.
// - Overvoltage codes 250/450/650/850 mV; auxiliary 11 gives 650 mV.
// - Overvoltage command sets both sections from two separate fields.
// - Trim 000/100 pin rate, 001 -10%, 010 -20%, 101 +10%, 110 +20%.
// - Trim codes 011 and 111 leave the setting alone.
// - Droop 00 quarter, 01 half, 10 ignored, 11 disabled.
// - Light-load choice 0 gives one phase, 1 gives two.
// - Phase shedding uses the same phase choice.
// - Hint enable 1 acts on the CPU hint, 0 ignores it.
// - Shedding enable resets to 0 and needs a written 1.
// - Flags bits [4:5] select shed threshold; bits [1:3] ignored.
// - Sign 1 positive, 0 negative; auxiliary ignores negative offsets.
// - Offset code in stream bits 4..8, bit 4 most significant.
// - Overvoltage bits 5:6 auxiliary, 7:8 core.
`include "pm_cmd_regs.svh"
module power_manager_command_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [15:0] coreVidMv,
    input wire logic [15:0] auxVidMv,
    input wire logic cpuLightLoadHint,
    input wire logic shedBelowThreshold,
    output logic [15:0] coreRefMv,
    output logic [15:0] auxRefMv,
    output logic [9:0] coreOvMv,
    output logic [9:0] auxOvMv,
    output logic freqFromPin,
    output logic [5:0] freqTrimPct,
    output logic coreDroopOn,
    output logic coreDroopHalf,
    output logic auxDroopOn,
    output logic auxDroopHalf,
    output logic [1:0] shedThresholdSel,
    output logic shedEnable,
    output logic phaseReduce,
    output logic [1:0] reducedPhases,
    output logic coreStepping,
    output logic auxStepping
);
    logic [1:0] coreOv_r, coreOv_nxt, auxOv_r, auxOv_nxt;
    logic [2:0] fsw_r, fsw_nxt;
    logic [1:0] coreDrp_r, coreDrp_nxt, auxDrp_r, auxDrp_nxt;
    logic [1:0] th_r, th_nxt;
    logic choice_r, choice_nxt, hint_r, hint_nxt, shed_r, shed_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [15:0] coreRef_r, coreRef_nxt, auxRef_r, auxRef_nxt;
    logic [7:0] tickCnt_r, tickCnt_nxt;
    logic stepTick;
    logic coreLoad, auxLoad;
    logic signed [5:0] coreTarget, auxTarget, coreOfs, auxOfs;
    logic isOfs;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Overvoltage threshold in mV for a 2-bit code.
    function automatic logic [9:0] ovrMv(input logic [1:0] code, input logic isCore);
        unique case (code)
            2'h0: ovrMv = `OVR_250_MV;
            2'h1: ovrMv = `OVR_450_MV;
            2'h2: ovrMv = `OVR_650_MV;
            2'h3: ovrMv = isCore ? `OVR_850_MV : `OVR_650_MV;
        endcase
    endfunction

    // Reference with offset; core clamps absolutely, auxiliary relative to its base.
    function automatic logic [15:0] refCalc(input logic [15:0] programmed_voltage_code,
                                            input logic signed [5:0] ofs,
                                            input logic isCore);
        logic [16:0] mag;
        logic [16:0] sum;
        mag = 17'($unsigned(ofs[5] ? -ofs : ofs)) * `OFS_STEP_MV;
        if (ofs[5]) begin
            sum = ({1'b0, programmed_voltage_code} > mag) ? {1'b0, programmed_voltage_code} - mag : 17'h00000;
        end else if (!isCore && mag > `AUX_MAX_OFS_MV) begin
            sum = {1'b0, programmed_voltage_code} + `AUX_MAX_OFS_MV;
        end else begin
            sum = {1'b0, programmed_voltage_code} + mag;
        end
        if (isCore && sum > `CORE_MAX_MV) begin
            sum = `CORE_MAX_MV;
        end
        refCalc = sum[16] ? 16'hFFFF : sum[15:0];
    endfunction

    // Step pacing divider; an offset walk advances one code per tick.
    always_comb begin
        stepTick = (tickCnt_r == 8'(`STEP_CYCLES - 1));
        tickCnt_nxt = stepTick ? 8'h00 : tickCnt_r + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_r <= 8'h00;
        end else begin
            tickCnt_r <= tickCnt_nxt;
        end
    end

    // Offset dispatch: section bits pick the targets, 00 drops the command.
    always_comb begin
        isOfs = wr && addr[`CMD_OFS_BIT];
        coreLoad = isOfs && addr[`CMD_CORE_BIT];
        auxLoad = isOfs && addr[`CMD_AUX_BIT] && wdata[`OFS_SIGN];
        coreTarget = wdata[`OFS_SIGN] ? $signed({1'b0, wdata[`OFS_HI:0]})
                                      : -$signed({1'b0, wdata[`OFS_HI:0]});
        auxTarget = $signed({1'b0, wdata[`OFS_HI:0]});
    end

    offset_stepper coreStep (
        .clk(clk),
        .rst_n(rst_n),
        .stepTick(stepTick),
        .loadTarget(coreLoad),
        .newTarget(coreTarget),
        .offsetNow(coreOfs),
        .busy(coreStepping)
    );

    offset_stepper auxStep (
        .clk(clk),
        .rst_n(rst_n),
        .stepTick(stepTick),
        .loadTarget(auxLoad),
        .newTarget(auxTarget),
        .offsetNow(auxOfs),
        .busy(auxStepping)
    );

    // Settings: only the command that names a field may change it.
    always_comb begin
        coreOv_nxt = coreOv_r;
        auxOv_nxt = auxOv_r;
        fsw_nxt = fsw_r;
        coreDrp_nxt = coreDrp_r;
        auxDrp_nxt = auxDrp_r;
        th_nxt = th_r;
        choice_nxt = choice_r;
        hint_nxt = hint_r;
        shed_nxt = shed_r;
        if (wr && !addr[`CMD_OFS_BIT]) begin
            unique case (addr)
                `CMD_OVR: begin
                    auxOv_nxt = wdata[`AUXF_HI:`AUXF_LO];
                    coreOv_nxt = wdata[`COREF_HI:`COREF_LO];
                end
                `CMD_FSW: begin
                    if (wdata[1:0] != 2'h3) begin
                        fsw_nxt = wdata[`FSW_HI:0];
                    end
                end
                `CMD_DRP: begin
                    if (wdata[`AUXF_HI:`AUXF_LO] != 2'h2) begin
                        auxDrp_nxt = wdata[`AUXF_HI:`AUXF_LO];
                    end
                    if (wdata[`COREF_HI:`COREF_LO] != 2'h2) begin
                        coreDrp_nxt = wdata[`COREF_HI:`COREF_LO];
                    end
                end
                `CMD_FLG: begin
                    th_nxt = wdata[`TH_HI:`TH_LO];
                    choice_nxt = wdata[`FLG_CHOICE];
                    hint_nxt = wdata[`FLG_HINT];
                    shed_nxt = wdata[`FLG_SHED];
                end
                default: begin
                end
            endcase
        end
        coreRef_nxt = refCalc(coreVidMv, coreOfs, 1'b1);
        auxRef_nxt = refCalc(auxVidMv, auxOfs, 1'b0);
    end

    // Readback of settings and walk status, valid the cycle after rd.
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd) begin
            unique case (addr)
                `RD_OVR: rdata_nxt = {4'h0, auxOv_r, coreOv_r};
                `RD_FSW: rdata_nxt = {5'h00, fsw_r};
                `RD_DRP: rdata_nxt = {4'h0, auxDrp_r, coreDrp_r};
                `RD_FLG: rdata_nxt = {3'h0, th_r, choice_r, hint_r, shed_r};
                `RD_CORE_OFS: rdata_nxt = {{2{coreOfs[5]}}, coreOfs};
                `RD_AUX_OFS: rdata_nxt = {{2{auxOfs[5]}}, auxOfs};
                `RD_STATUS: rdata_nxt = {6'h00, auxStepping, coreStepping};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Settings registers; reset values are the power-up defaults.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreOv_r <= `OVR_RST;
            auxOv_r <= `OVR_RST;
            fsw_r <= `FSW_RST;
            coreDrp_r <= `DRP_RST;
            auxDrp_r <= `DRP_RST;
            th_r <= `TH_RST;
            choice_r <= `CHOICE_RST;
            hint_r <= `HINT_RST;
            shed_r <= `SHED_RST;
            rdata_r <= 8'h00;
            coreRef_r <= 16'h0000;
            auxRef_r <= 16'h0000;
        end else begin
            coreOv_r <= coreOv_nxt;
            auxOv_r <= auxOv_nxt;
            fsw_r <= fsw_nxt;
            coreDrp_r <= coreDrp_nxt;
            auxDrp_r <= auxDrp_nxt;
            th_r <= th_nxt;
            choice_r <= choice_nxt;
            hint_r <= hint_nxt;
            shed_r <= shed_nxt;
            rdata_r <= rdata_nxt;
            coreRef_r <= coreRef_nxt;
            auxRef_r <= auxRef_nxt;
        end
    end

    // Decoded views of the stored codes.
    always_comb begin
        coreOvMv = ovrMv(coreOv_r, 1'b1);
        auxOvMv = ovrMv(auxOv_r, 1'b0);
        freqFromPin = (fsw_r[1:0] == 2'h0);
        unique case (fsw_r)
            3'h1: freqTrimPct = `FSW_M10;
            3'h2: freqTrimPct = `FSW_M20;
            3'h5: freqTrimPct = `FSW_P10;
            3'h6: freqTrimPct = `FSW_P20;
            default: freqTrimPct = 6'h00;
        endcase
        coreDroopOn = (coreDrp_r != 2'h3);
        coreDroopHalf = (coreDrp_r == 2'h1);
        auxDroopOn = (auxDrp_r != 2'h3);
        auxDroopHalf = (auxDrp_r == 2'h1);
        // The same phase choice serves the hint and automatic shedding.
        phaseReduce = (hint_r && cpuLightLoadHint) || (shed_r && shedBelowThreshold);
        reducedPhases = choice_r ? 2'h2 : 2'h1;
    end

    assign rdata = rdata_r;
    assign coreRefMv = coreRef_r;
    assign auxRefMv = auxRef_r;
    assign shedThresholdSel = th_r;
    assign shedEnable = shed_r;

    AST_SECTION_NONE: assert property (wr && addr == 3'h4 |-> !coreLoad && !auxLoad)
        else $error("Offset command with no section bits was not ignored.");
    AST_AUX_NEG: assert property (auxLoad |-> wdata[`OFS_SIGN])
        else $error("Auxiliary rail took a negative offset.");
    AST_CORE_CLAMP: assert property (coreRefMv <= 16'h0AF0)
        else $error("Core reference above clamp.");
    AST_AUX_CAP: assert property (##1 {1'b0, auxRefMv} <= {1'b0, $past(auxVidMv)} + 17'h00258)
        else $error("Auxiliary reference above its cap.");
    AST_FSW_KEEP: assert property (wr && addr == 3'h1 && wdata[1:0] == 2'h3
        |=> $stable(freqTrimPct) && $stable(freqFromPin))
        else $error("Ignored trim code changed the frequency.");
    AST_DRP_OFF: assert property (wr && addr == 3'h2 && wdata[1:0] == 2'h3 |=> !coreDroopOn)
        else $error("Core droop not disabled.");
    AST_SHED: assert property (wr && addr == 3'h3 |=> shedEnable == $past(wdata[0]))
        else $error("Shedding enable not taken from bit 8.");
    AST_OVR_CORE: assert property (wr && addr == 3'h0 && wdata[1:0] == 2'h3
        |=> coreOvMv == 10'h352 && auxOvMv == (($past(wdata[3:2]) == 2'h3) ? 10'h28A : auxOvMv))
        else $error("Core overvoltage code 11 not 850 mV.");
    AST_HINT: assert property (cpuLightLoadHint && !hint_r && !shedEnable |-> !phaseReduce)
        else $error("Hint acted on while disabled.");
    // Decoded outputs other than the droop code 10 case checked against fixed codes, so a broken decode trips them.
    AST_FSW_PLUS: assert property (wr && addr == 3'h1 && wdata[2:0] == 3'h5
        |=> freqTrimPct == 6'h0A && !freqFromPin)
        else $error("Trim code 101 did not give plus ten percent.");
    AST_FSW_PIN: assert property (wr && addr == 3'h1 && wdata[1:0] == 2'h0
        |=> freqFromPin && freqTrimPct == 6'h00)
        else $error("Trim code 000 or 100 did not restore the pin rate.");
    AST_DRP_SKIP: assert property (wr && addr == 3'h2 && wdata[1:0] == 2'h2
        |=> $stable(coreDroopOn) && $stable(coreDroopHalf))
        else $error("Droop code 10 changed the core droop.");
    AST_OVR_AUX: assert property (wr && addr == 3'h0 && wdata[3:2] == 2'h3
        |=> auxOvMv == 10'h28A)
        else $error("Auxiliary overvoltage code 11 not 650 mV.");
    AST_WALK_START: assert property (coreLoad && !stepTick && coreTarget != coreOfs
        |=> coreStepping)
        else $error("Core offset walk did not start.");
    AST_SHED_REDUCE: assert property (shedEnable && shedBelowThreshold
        |-> phaseReduce)
        else $error("Enabled shedding below threshold did not reduce phases.");
endmodule // power_manager_command_decoder

// ===== pm_master_model.sv
// Purpose: Power manager side of the command bus, issuing commands and reads.
// Assumes: One strobe per call; the decoder samples at the rising edge.
// Notes: Released address and data lines show the inverse of the last value.
module pm_master_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [2:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idles with both strobes low from time zero.
    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One command byte; the code travels on the address lines.
    task automatic sendCmd(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken then.
    task automatic readReg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule // pm_master_model

// ===== power_manager_command_decoder_tb.sv
// Purpose: Self-checking bench comparing the decoder with an integer model.
// Assumes: Offset walk of one code per 100 cycles, refs one cycle behind.
// Notes: Random upper bits check that ignored stream bits stay ignored.
module power_manager_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, wr, rd, hint, below, freqFromPin, shedEnable, phaseReduce;
    logic coreDroopOn, coreDroopHalf, auxDroopOn, auxDroopHalf, coreStepping, auxStepping;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, b, r;
    logic [15:0] coreVidMv, auxVidMv, coreRefMv, auxRefMv;
    logic [9:0] coreOvMv, auxOvMv;
    logic [5:0] freqTrimPct;
    logic [1:0] shedThresholdSel, reducedPhases;
    int mismatches, compares, seed;
    int ovC, ovA, tPin, tPct, dC, dA, th, ch, he, se, cCode, aCode;

    power_manager_command_decoder dut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .coreVidMv(coreVidMv),
        .auxVidMv(auxVidMv), .cpuLightLoadHint(hint), .shedBelowThreshold(below),
        .coreRefMv(coreRefMv), .auxRefMv(auxRefMv), .coreOvMv(coreOvMv),
        .auxOvMv(auxOvMv), .freqFromPin(freqFromPin), .freqTrimPct(freqTrimPct),
        .coreDroopOn(coreDroopOn), .coreDroopHalf(coreDroopHalf),
        .auxDroopOn(auxDroopOn), .auxDroopHalf(auxDroopHalf),
        .shedThresholdSel(shedThresholdSel), .shedEnable(shedEnable),
        .phaseReduce(phaseReduce), .reducedPhases(reducedPhases),
        .coreStepping(coreStepping), .auxStepping(auxStepping));
    pm_master_model master (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chkSet(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkRef(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkRd(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [9:0] ovMv(int c, int aux);
        case (c)
            0: return 10'h0FA;
            1: return 10'h1C2;
            2: return 10'h28A;
            default: return (aux != 0) ? 10'h28A : 10'h352;
        endcase
    endfunction

    // Model state after reset; the offsets go back to zero as well.
    task automatic setDefaults();
        {ovC, ovA, tPct, dC, dA, th, ch, se, cCode, aCode} = '0;
        tPin = 1;
        he = 1;
    endtask

    // Every static setting against the model.
    task automatic checkAll();
        chkSet(coreOvMv, ovMv(ovC, 0));
        chkSet(auxOvMv, ovMv(ovA, 1));
        chkSet(10'(freqFromPin), 10'(tPin));
        chkSet(10'(freqTrimPct), 10'($unsigned(6'(tPct))));
        chkSet(10'({coreDroopOn, auxDroopOn}), 10'({dC != 3, dA != 3}));
        chkSet(10'({coreDroopHalf & coreDroopOn, auxDroopHalf & auxDroopOn}),
            10'({dC == 1, dA == 1}));
        chkSet(10'(shedThresholdSel), 10'(th));
        chkSet(10'(shedEnable), 10'(se));
        chkSet(10'(reducedPhases), 10'(ch + 1));
        chkSet(10'(phaseReduce), 10'((he & hint) | (se & below)));
    endtask

    // Negative core sums floor at zero, a choice of the design.
    task automatic checkRefs();
        int c;
        int a;
        c = int'(coreVidMv) + 50 * cCode;
        a = int'(auxVidMv) + 50 * aCode;
        c = (c > 2800) ? 2800 : ((c < 0) ? 0 : c);
        a = (a > int'(auxVidMv) + 600) ? int'(auxVidMv) + 600 : a;
        chkRef(coreRefMv, 16'(c));
        chkRef(auxRefMv, 16'(a));
    endtask

    task automatic ofs(input logic [1:0] sec, input logic sign, input logic [4:0] code);
        b = {2'($random(seed)), sign, code};
        master.sendCmd({1'b1, sec}, b);
        cCode = sec[1] ? (sign ? int'(code) : -int'(code)) : cCode;
        aCode = (sec[0] && sign) ? int'(code) : aCode;
    endtask

    // Bounded wait for both walks to end, then for the refs to follow.
    task automatic waitIdle();
        int n;
        n = 0;
        #1;
        while ((coreStepping !== 1'b0 || auxStepping !== 1'b0) && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 5000) begin
            mismatches++;
            conclude();
        end
        repeat (2) @(posedge clk);
        #1;
        checkRefs();
    endtask

    // Main sequence: defaults, every overvoltage, trim and droop code, random flags, offsets, reset again.
    initial begin
        seed = 48;
        {clk, rst_n, hint, below} = '0;
        coreVidMv = 16'h03E8;
        auxVidMv = 16'h04B0;
        setDefaults();
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        checkAll();
        checkRefs();
        for (int i = 0; i < 16; i++) begin
            b = 8'($random(seed));
            b[3:0] = 4'(i);
            master.sendCmd(3'h0, b);
            ovA = b[3:2];
            ovC = b[1:0];
            #1;
            checkAll();
        end
        master.readReg(3'h0, r);
        chkRd(r, {4'h0, 2'(ovA), 2'(ovC)});
        // Trim 011 and 111 follow -20% and +20% and must leave them standing.
        for (int i = 0; i < 8; i++) begin
            b = {5'($random(seed)), 3'(i)};
            master.sendCmd(3'h1, b);
            if (i % 4 != 3) begin
                tPin = (i % 4 == 0);
                tPct = (i % 4) * ((i > 3) ? 10 : -10);
            end
            #1;
            checkAll();
        end
        master.readReg(3'h1, r);
        chkRd(r, 8'h06);
        for (int i = 0; i < 16; i++) begin
            b = {4'($random(seed)), 4'(i)};
            master.sendCmd(3'h2, b);
            dC = (b[1:0] == 2'h2) ? dC : b[1:0];
            dA = (b[3:2] == 2'h2) ? dA : b[3:2];
            #1;
            checkAll();
        end
        master.readReg(3'h2, r);
        chkRd(r, {4'h0, 2'(dA), 2'(dC)});
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            hint <= 1'($random(seed));
            below <= 1'($random(seed));
            b = 8'($random(seed));
            master.sendCmd(3'h3, b);
            {th, ch, he, se} = {30'h0, b[4:3], 31'h0, b[2], 31'h0, b[1], 31'h0, b[0]};
            #1;
            checkAll();
        end
        master.readReg(3'h3, r);
        chkRd(r, {3'h0, 2'(th), 1'(ch), 1'(he), 1'(se)});
        ofs(2'h2, 1'b1, 5'h03);
        #1;
        chkSet(10'(coreStepping), 10'h001);
        waitIdle();
        ofs(2'h3, 1'b1, 5'h1F);
        master.readReg(3'h6, r);
        chkRd(r, 8'h03);
        repeat (150) @(posedge clk);
        ofs(2'h3, 1'b1, 5'h02);
        waitIdle();
        ofs(2'h1, 1'b1, 5'h1F);
        #1;
        chkSet(10'(auxStepping), 10'h001);
        waitIdle();
        master.readReg(3'h5, r);
        chkRd(r, 8'(aCode));
        ofs(2'h3, 1'b0, 5'h04);
        waitIdle();
        ofs(2'h0, 1'b1, 5'h09);
        waitIdle();
        @(posedge clk);
        coreVidMv <= 16'h07D0;
        ofs(2'h2, 1'b1, 5'h1F);
        waitIdle();
        master.readReg(3'h4, r);
        chkRd(r, 8'h1F);
        master.readReg(3'h7, r);
        chkRd(r, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        setDefaults();
        @(posedge clk);
        #1;
        checkAll();
        checkRefs();
        conclude();
    end
endmodule // power_manager_command_decoder_tb
